// ### common/pmd_cfg.svh
// Offsets, field positions, reset values and timing counts of the panel monitor
`ifndef PMD_CFG_SVH
`define PMD_CFG_SVH

// Clock rate and the pulse-rate window
`define PMD_CLK_MHZ 125
`define PMD_RATE_WINDOW_US 1000
`define PMD_RATE_WINDOW_CYCLES (`PMD_RATE_WINDOW_US * `PMD_CLK_MHZ)

// Register byte offsets
`define PMD_CTRL_OFF 8'h00
`define PMD_INV_OFF 8'h04
`define PMD_STATE_OFF 8'h08
`define PMD_DISP_OFF 8'h0c
`define PMD_RATE_OFF 8'h10

// Field positions
`define PMD_CTRL_VIRT_BIT 0
`define PMD_STATE_SHOW_BIT 2
`define PMD_STATE_ITEM_LSB 8

// Reset values
`define PMD_CTRL_RST 1'b0
`define PMD_INV_RST 4'h0

// Monitor item numbers and the last stepping index
`define PMD_ITEM_SPEED 5'd0
`define PMD_ITEM_SPEED_REF 5'd1
`define PMD_ITEM_TORQUE_REF 5'd2
`define PMD_ITEM_TORQUE_INT 5'd3
`define PMD_ITEM_ENC_ANGLE 5'd4
`define PMD_ITEM_INPUTS 5'd5
`define PMD_ITEM_PROBE 5'd6
`define PMD_ITEM_OUTPUTS 5'd7
`define PMD_ITEM_PULSE_RATE 5'd8
`define PMD_ITEM_REF_COUNT 5'd9
`define PMD_ITEM_DEVIATION 5'd11
`define PMD_ITEM_REF_PULSE 5'd13
`define PMD_ITEM_INERTIA 5'd15
`define PMD_ITEM_OVERLOAD 5'd16
`define PMD_ITEM_BUS_VOLT 5'd19
`define PMD_ITEM_ENC_TEMP 5'd21
`define PMD_ITEM_BOARD_TEMP 5'd22
`define PMD_ITEM_PCP_TARGET 5'd24
`define PMD_ITEM_LAST_IDX 5'd17

`endif

// ### common/pmd_pkg.sv
// Types shared by the panel monitor files
package pmd_pkg;

	// Panel operating modes, stepped in this order by the mode key
	typedef enum logic [1:0] {
		mode_status,
		mode_param,
		mode_monitor,
		mode_utility
	} pmd_mode_type;

endpackage

// ### verilog/pmd_sync_edge.sv
// Two-flop synchroniser with rising-edge detect for a vector of pins
`timescale 1ns/1ns
module pmd_sync_edge #(
	parameter int W = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	logic [W-1:0] meta;
	logic [W-1:0] last;

	// First stage feeds only the second; edges are taken after it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '0;
			level <= '0;
			last <= '0;
		end else begin
			meta <= pin;
			level <= meta;
			last <= level;
		end
	end

	assign rise = level & ~last;
endmodule

// ### verilog/pmd_rate_window.sv
// Counts pulse edges in fixed windows and holds the last full count
`timescale 1ns/1ns
module pmd_rate_window #(
	parameter int WINDOW_CYCLES = 125000,
	parameter int CNT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pulse_rise,
	output logic [CNT_W-1:0] rate
);
	localparam int CYC_W = $clog2(WINDOW_CYCLES);
	logic [CYC_W-1:0] cyc;
	logic [CNT_W-1:0] acc;
	logic tick;

	assign tick = (cyc == CYC_W'(WINDOW_CYCLES - 1));

	// Window divider: one tick pulse per window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc <= '0;
		end else if (tick) begin
			cyc <= '0;
		end else begin
			cyc <= cyc + 1'b1;
		end
	end

	// Accumulate; saturate rather than wrap so a flood never reads small
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= '0;
			rate <= '0;
		end else if (tick) begin
			rate <= (&acc) ? acc : acc + {{(CNT_W-1){1'b0}}, pulse_rise}; // see (R6)
			acc <= '0;
		end else if (pulse_rise && !(&acc)) begin
			acc <= acc + 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_rate_latch;
		(tick && !pulse_rise) |=> (rate == $past(acc)) && (acc == '0);
	endproperty
	a_rate_latch: assert property (p_rate_latch) else $error("rate not latched"); // see (R6)

	property p_window_restart;
		tick |=> (cyc == '0) ##1 !tick;
	endproperty
	a_window_restart: assert property (p_window_restart) else $error("window bad"); // see (R6)

	c_rate_nonzero: cover property (tick && acc != '0);
endmodule

// ### verilog/pmd_top.sv
// Front-panel monitor mode: key stepping, item display and APB registers
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "pmd_cfg.svh"
// What this block does
// (R1) Monitor mode reachable while motor runs
// (R2) Mode key steps to next mode
// (R3) Up/down step monitor item number
// (R4) Enter toggles item number and value
// (R5) Fixed item numbers map to quantities
// (R6) Pulse rate counts pulses per millisecond
// (R7) Inputs shown as hex digits, high=1
// (R8) Digit bits ordered right to left
// (R9) Virtual digits: bits 12-15, 8-11, 4-7
// (R10) Probe shown as binary, high=1
// (R11) Four outputs shown as binary columns
// (R12) Non-inverted: lit when optocoupler on
// (R13) Inverted: lit when optocoupler off
module pmd_top #(
	parameter int RATE_WINDOW_CYCLES = `PMD_RATE_WINDOW_CYCLES,
	parameter int RATE_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic key_mode,
	input wire logic key_up,
	input wire logic key_down,
	input wire logic key_enter,
	input wire logic ref_pulse_pin,
	input wire logic [7:0] din_pins,
	input wire logic probe_input_one,
	input wire logic [15:4] virt_bits,
	input wire logic [3:0] opto_on,
	input wire logic [31:0] speed_rpm,
	input wire logic [31:0] speed_ref_rpm,
	input wire logic [31:0] torque_ref_pct,
	input wire logic [31:0] internal_torque_item,
	input wire logic [31:0] enc_angle,
	input wire logic [31:0] ref_pulse_count,
	input wire logic [31:0] deviation_count,
	input wire logic [31:0] ref_pulse_total,
	input wire logic [31:0] inertia_pct,
	input wire logic [31:0] overload_pct,
	input wire logic [31:0] bus_voltage,
	input wire logic [31:0] enc_temp,
	input wire logic [31:0] board_temp,
	input wire logic [31:0] pcp_target,
	output pmd_pkg::pmd_mode_type panel_mode,
	output logic [4:0] monitor_item,
	output logic show_value,
	output logic [31:0] disp_word
);
	import pmd_pkg::*;

	// ****************************************************
	// Input synchronisers
	// ****************************************************
	logic [4:0] key_rise;
	logic [8:0] pin_level;
	logic key_mode_rise;
	logic key_up_rise;
	logic key_down_rise;
	logic key_enter_rise;
	logic pulse_rise;
	logic [7:0] din_s;
	logic probe_s;

	// Keys and pulse pin share one vector of synchronisers
	pmd_sync_edge #(.W(5)) u_keys (
		.pclk(pclk),
		.presetn(presetn),
		.pin({ref_pulse_pin, key_enter, key_down, key_up, key_mode}),
		.level(),
		.rise(key_rise)
	);

	// Level inputs need no edge, only a clean sample
	pmd_sync_edge #(.W(9)) u_levels (
		.pclk(pclk),
		.presetn(presetn),
		.pin({probe_input_one, din_pins}),
		.level(pin_level),
		.rise()
	);

	assign key_mode_rise = key_rise[0];
	assign key_up_rise = key_rise[1];
	assign key_down_rise = key_rise[2];
	assign key_enter_rise = key_rise[3];
	assign pulse_rise = key_rise[4];
	assign din_s = pin_level[7:0];
	assign probe_s = pin_level[8];

	// ****************************************************
	// Pulse rate window
	// ****************************************************
	logic [RATE_W-1:0] pulse_rate_item;

	pmd_rate_window #(.WINDOW_CYCLES(RATE_WINDOW_CYCLES), .CNT_W(RATE_W)) u_rate (
		.pclk(pclk),
		.presetn(presetn),
		.pulse_rise(pulse_rise),
		.rate(pulse_rate_item)
	);

	// ****************************************************
	// Item table
	// ****************************************************
	// Maps the stepping index onto the sparse item numbers
	function automatic logic [4:0] item_num(input logic [4:0] idx);
		case (idx)
			5'd0: item_num = `PMD_ITEM_SPEED;
			5'd1: item_num = `PMD_ITEM_SPEED_REF;
			5'd2: item_num = `PMD_ITEM_TORQUE_REF;
			5'd3: item_num = `PMD_ITEM_TORQUE_INT;
			5'd4: item_num = `PMD_ITEM_ENC_ANGLE;
			5'd5: item_num = `PMD_ITEM_INPUTS;
			5'd6: item_num = `PMD_ITEM_PROBE;
			5'd7: item_num = `PMD_ITEM_OUTPUTS;
			5'd8: item_num = `PMD_ITEM_PULSE_RATE;
			5'd9: item_num = `PMD_ITEM_REF_COUNT;
			5'd10: item_num = `PMD_ITEM_DEVIATION;
			5'd11: item_num = `PMD_ITEM_REF_PULSE;
			5'd12: item_num = `PMD_ITEM_INERTIA;
			5'd13: item_num = `PMD_ITEM_OVERLOAD;
			5'd14: item_num = `PMD_ITEM_BUS_VOLT;
			5'd15: item_num = `PMD_ITEM_ENC_TEMP;
			5'd16: item_num = `PMD_ITEM_BOARD_TEMP;
			default: item_num = `PMD_ITEM_PCP_TARGET;
		endcase
	endfunction

	// ****************************************************
	// Registers written by software
	// ****************************************************
	logic virt_sel;
	logic [3:0] out_invert;
	logic wr_strobe;
	logic [4:0] item_idx;

	assign wr_strobe = psel && penable && pready && pwrite;

	// Control: input monitor source select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			virt_sel <= `PMD_CTRL_RST;
		end else if (wr_strobe && paddr == `PMD_CTRL_OFF) begin
			virt_sel <= pwdata[`PMD_CTRL_VIRT_BIT];
		end
	end

	// Output polarity: a set bit marks that output as inverted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_invert <= `PMD_INV_RST;
		end else if (wr_strobe && paddr == `PMD_INV_OFF) begin
			out_invert <= pwdata[3:0];
		end
	end

	// ****************************************************
	// Panel mode and monitor navigation
	// ****************************************************
	// No servo state gates this: monitor mode is reached while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			panel_mode <= mode_status;
		end else if (key_mode_rise) begin
			panel_mode <= pmd_mode_type'(2'(panel_mode) + 2'd1); // see (R2) see (R1)
		end
	end

	// Mode key wins over the others; up wins when up and down coincide
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			item_idx <= 5'd0;
			show_value <= 1'b0;
		end else if (key_mode_rise) begin
			show_value <= 1'b0;
		end else if (panel_mode == mode_monitor) begin
			if (key_enter_rise) begin
				show_value <= !show_value; // see (R4)
			end else if (!show_value && key_up_rise) begin
				item_idx <= (item_idx == `PMD_ITEM_LAST_IDX) ? 5'd0 : item_idx + 5'd1; // see (R3)
			end else if (!show_value && key_down_rise) begin
				item_idx <= (item_idx == 5'd0) ? `PMD_ITEM_LAST_IDX : item_idx - 5'd1; // see (R3)
			end
		end
	end

	// ****************************************************
	// Item values
	// ****************************************************
	logic [31:0] item_value;
	logic [31:0] input_word;
	logic [31:0] output_word;

	// Left digit holds the first pin group; bit 0 is the rightmost pin
	assign input_word = virt_sel ?
		{20'h0, virt_bits[15:12], virt_bits[11:8], virt_bits[7:4]} : // see (R9)
		{24'h0, din_s[3:0], din_s[7:4]}; // see (R7) see (R8)
	// Lit column follows the drive for normal outputs and its inverse otherwise
	assign output_word = {28'h0, opto_on ^ out_invert}; // see (R11) see (R12) see (R13)

	// Live value mux by item number
	always_comb begin
		item_value = 32'h0;
		case (item_num(item_idx))
			`PMD_ITEM_SPEED: item_value = speed_rpm; // see (R5)
			`PMD_ITEM_SPEED_REF: item_value = speed_ref_rpm;
			`PMD_ITEM_TORQUE_REF: item_value = torque_ref_pct;
			`PMD_ITEM_TORQUE_INT: item_value = internal_torque_item;
			`PMD_ITEM_ENC_ANGLE: item_value = enc_angle;
			`PMD_ITEM_INPUTS: item_value = input_word;
			`PMD_ITEM_PROBE: item_value = {31'h0, probe_s}; // see (R10)
			`PMD_ITEM_OUTPUTS: item_value = output_word;
			`PMD_ITEM_PULSE_RATE: item_value = 32'(pulse_rate_item); // see (R6)
			`PMD_ITEM_REF_COUNT: item_value = ref_pulse_count;
			`PMD_ITEM_DEVIATION: item_value = deviation_count;
			`PMD_ITEM_REF_PULSE: item_value = ref_pulse_total;
			`PMD_ITEM_INERTIA: item_value = inertia_pct;
			`PMD_ITEM_OVERLOAD: item_value = overload_pct;
			`PMD_ITEM_BUS_VOLT: item_value = bus_voltage;
			`PMD_ITEM_ENC_TEMP: item_value = enc_temp;
			`PMD_ITEM_BOARD_TEMP: item_value = board_temp;
			`PMD_ITEM_PCP_TARGET: item_value = pcp_target;
			default: item_value = 32'h0;
		endcase
	end

	// Display word trails the selection by one cycle so values stay live
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_word <= 32'h0;
			monitor_item <= 5'd0;
		end else begin
			monitor_item <= item_num(item_idx);
			disp_word <= show_value ? item_value : {27'h0, item_num(item_idx)}; // see (R4)
		end
	end

	// ****************************************************
	// APB slave
	// ****************************************************
	logic [31:0] rd_mux;
	logic rd_hit;

	// Read decode; unmapped addresses answer with an error
	always_comb begin
		rd_mux = 32'h0;
		rd_hit = 1'b1;
		case (paddr)
			`PMD_CTRL_OFF: rd_mux = {31'h0, virt_sel};
			`PMD_INV_OFF: rd_mux = {28'h0, out_invert};
			`PMD_STATE_OFF: rd_mux = {19'h0, monitor_item, 5'h0, show_value, 2'(panel_mode)};
			`PMD_DISP_OFF: rd_mux = disp_word;
			`PMD_RATE_OFF: rd_mux = 32'(pulse_rate_item);
			default: rd_hit = 1'b0;
		endcase
	end

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !rd_hit;
			prdata <= pwrite ? 32'h0 : rd_mux;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ****************************************************
	// Assertions
	// ****************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_mode_step;
		key_mode_rise |=> panel_mode == pmd_mode_type'(2'($past(panel_mode)) + 2'd1);
	endproperty
	a_mode_step: assert property (p_mode_step) else $error("mode not stepped"); // see (R2)

	property p_enter_running;
		(key_mode_rise && panel_mode == mode_param && speed_rpm != 32'h0)
			|=> panel_mode == mode_monitor ##1 !show_value;
	endproperty
	a_enter_running: assert property (p_enter_running) else $error("monitor blocked"); // see (R1)

	property p_item_up;
		(panel_mode == mode_monitor && !show_value && key_up_rise && !key_mode_rise
			&& !key_enter_rise) |=> item_idx == (($past(item_idx) == 5'd17) ?
			5'd0 : $past(item_idx) + 5'd1);
	endproperty
	a_item_up: assert property (p_item_up) else $error("up step wrong"); // see (R3)

	property p_item_down;
		(panel_mode == mode_monitor && !show_value && key_down_rise && !key_up_rise
			&& !key_mode_rise && !key_enter_rise) |=> item_idx == (($past(item_idx) == 5'd0)
			? 5'd17 : $past(item_idx) - 5'd1);
	endproperty
	a_item_down: assert property (p_item_down) else $error("down step wrong"); // see (R3)

	property p_enter_toggle;
		(panel_mode == mode_monitor && key_enter_rise && !key_mode_rise)
			|=> show_value != $past(show_value) ##1 (!show_value ||
			disp_word == $past(item_value));
	endproperty
	a_enter_toggle: assert property (p_enter_toggle) else $error("enter no toggle"); // see (R4)

	property p_number_shown;
		!show_value |=> disp_word == {27'h0, item_num($past(item_idx))};
	endproperty
	a_number_shown: assert property (p_number_shown) else $error("number not shown"); // see (R4)

	property p_speed_item;
		(show_value && item_idx == 5'd0) |=> disp_word == $past(speed_rpm);
	endproperty
	a_speed_item: assert property (p_speed_item) else $error("speed item wrong"); // see (R5)

	property p_din_digits;
		(show_value && item_idx == 5'd5 && !virt_sel)
			|=> disp_word == {24'h0, $past(din_s[3:0]), $past(din_s[7:4])};
	endproperty
	a_din_digits: assert property (p_din_digits) else $error("input digits wrong"); // see (R7)

	property p_virt_digits;
		(show_value && item_idx == 5'd5 && virt_sel)
			|=> disp_word[11:0] == $past(virt_bits) && disp_word[31:12] == 20'h0;
	endproperty
	a_virt_digits: assert property (p_virt_digits) else $error("virtual digits wrong"); // see (R9)

	property p_probe;
		(show_value && item_idx == 5'd6) |=> disp_word == {31'h0, $past(probe_s)};
	endproperty
	a_probe: assert property (p_probe) else $error("probe column wrong"); // see (R10)

	// Every non-inverted column must follow its drive
	property p_out_plain;
		(show_value && item_idx == 5'd7) |=>
			((disp_word[3:0] ^ $past(opto_on)) & ~$past(out_invert)) == 4'h0;
	endproperty
	a_out_plain: assert property (p_out_plain) else $error("plain output wrong"); // see (R12)

	// Every inverted column must show the opposite of its drive
	property p_out_inv;
		(show_value && item_idx == 5'd7) |=>
			((disp_word[3:0] ^ ~$past(opto_on)) & $past(out_invert)) == 4'h0;
	endproperty
	a_out_inv: assert property (p_out_inv) else $error("inverted output wrong"); // see (R13)

	property p_apb_answer;
		(psel && penable && !pready) |=> pready ##1 !pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

	c_enter_monitor: cover property (key_mode_rise && panel_mode == mode_param);
	c_show_value: cover property (panel_mode == mode_monitor && show_value);
	c_wrap_down: cover property (key_down_rise && item_idx == 5'd0 && !show_value);
	c_apb_error: cover property (pready && pslverr);
endmodule

// ### test/pmd_panel_model.sv
// Keypad operator and reference pulse source facing the panel monitor
`timescale 1ns/1ns
module pmd_panel_model (
	input wire logic pclk,
	input wire logic presetn,
	output logic key_mode,
	output logic key_up,
	output logic key_down,
	output logic key_enter,
	output logic ref_pulse_pin
);
	logic [3:0] keys;
	logic [1:0] phase;

	// Keys are levels, high while the operator holds them
	assign key_mode = keys[0];
	assign key_up = keys[1];
	assign key_down = keys[2];
	assign key_enter = keys[3];
	assign ref_pulse_pin = phase[1];

	initial begin
		keys = 4'h0;
	end

	// Pulse train of period four, so any 20-cycle window holds five edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// Held past the synchroniser so it acts once, then settled before return
	task automatic press(input int k);
		@(posedge pclk);
		keys[k] <= 1'b1;
		repeat (6) @(posedge pclk);
		keys[k] <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the panel monitor: keys, item display and registers
`timescale 1ns/1ns
`include "pmd_cfg.svh"
module testbench;
	import pmd_pkg::*;
	localparam int win = 20;
	localparam logic [4:0] items_list [18] = '{5'd0, 5'd1, 5'd2, 5'd3, 5'd4, 5'd5,
		5'd6, 5'd7, 5'd8, 5'd9, 5'd11, 5'd13, 5'd15, 5'd16, 5'd19, 5'd21, 5'd22, 5'd24};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, show_value;
	logic key_mode, key_up, key_down, key_enter, ref_pulse_pin, probe_input_one, er;
	logic [7:0] paddr, din_pins;
	logic [31:0] pwdata, prdata, disp_word, rd;
	logic [15:4] virt_bits;
	logic [3:0] opto_on;
	logic [4:0] monitor_item;
	logic [31:0] qv [14];
	pmd_mode_type panel_mode;
	int mismatches, samples_checked, cycles, i, j;

	// ****************************************
	// Clock, partner and design
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	pmd_panel_model m (.pclk, .presetn, .key_mode, .key_up, .key_down, .key_enter,
		.ref_pulse_pin);

	// Short rate window keeps the pulse-count test brief
	pmd_top #(.RATE_WINDOW_CYCLES(win)) uut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .key_mode, .key_up,
		.key_down, .key_enter, .ref_pulse_pin, .din_pins, .probe_input_one,
		.virt_bits, .opto_on, .speed_rpm(qv[0]), .speed_ref_rpm(qv[1]),
		.torque_ref_pct(qv[2]), .internal_torque_item(qv[3]), .enc_angle(qv[4]),
		.ref_pulse_count(qv[5]), .deviation_count(qv[6]), .ref_pulse_total(qv[7]),
		.inertia_pct(qv[8]), .overload_pct(qv[9]), .bus_voltage(qv[10]),
		.enc_temp(qv[11]), .board_temp(qv[12]), .pcp_target(qv[13]),
		.panel_mode, .monitor_item, .show_value, .disp_word);

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// A hang on pready is cut short by the cycle ceiling below
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
		chk({31'h0, er}, {31'h0, e});
	endtask

	// Expected display value of list entry k, worked out from the live sources
	function automatic logic [31:0] exp_val(input int k);
		case (k)
			5: exp_val = {24'h0, din_pins[3:0], din_pins[7:4]};
			6: exp_val = {31'h0, probe_input_one};
			7: exp_val = {28'h0, opto_on ^ 4'h5};
			8: exp_val = 32'(win / 4);
			default: exp_val = qv[(k < 5) ? k : k - 4];
		endcase
	endfunction

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		din_pins = 8'hf3;
		probe_input_one = 1'b1;
		virt_bits = 12'habc;
		opto_on = 4'h3;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		for (i = 0; i < 14; i++) begin
			qv[i] = {16'hc0de, 11'h0, items_list[i < 5 ? i : i + 4]};
		end
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(32'(panel_mode), 32'(mode_status));
		chk({27'h0, monitor_item}, 32'h0);
		chk(disp_word, 32'h0);
		rd_chk(`PMD_CTRL_OFF, 32'h0, 1'b0);
		rd_chk(`PMD_INV_OFF, 32'h0, 1'b0);
		rd_chk(8'h20, 32'h0, 1'b1);
		apb(1'b1, `PMD_STATE_OFF, 32'hffff);
		rd_chk(`PMD_STATE_OFF, 32'h0, 1'b0);
		apb(1'b1, `PMD_INV_OFF, 32'h5);
		rd_chk(`PMD_INV_OFF, 32'h5, 1'b0);
		m.press(0);
		chk(32'(panel_mode), 32'(mode_param));
		m.press(0);
		chk(32'(panel_mode), 32'(mode_monitor));
		m.press(2);
		chk({27'h0, monitor_item}, 32'd24);
		m.press(1);
		for (i = 0; i < 18; i++) begin
			j = (i < 5) ? i : i - 4;
			chk({27'h0, monitor_item}, {27'h0, items_list[i]});
			m.press(3);
			chk({31'h0, show_value}, 32'h1);
			chk(disp_word, exp_val(i));
			if (i == 1) begin
				rd_chk(`PMD_STATE_OFF, 32'h0106, 1'b0);
			end
			// The shown source, except the pulse rate, is flipped live, so a path stuck at its old value shows
			qv[j] <= (i < 5 || i > 8) ? ~qv[j] : qv[j];
			din_pins <= (i == 5) ? ~din_pins : din_pins;
			probe_input_one <= (i == 6) ? ~probe_input_one : probe_input_one;
			opto_on <= (i == 7) ? ~opto_on : opto_on;
			repeat (5) @(posedge pclk);
			chk(disp_word, exp_val(i));
			// Virtual select is switched live while the input item is shown
			if (i == 5) begin
				apb(1'b1, `PMD_CTRL_OFF, 32'h1);
				repeat (4) @(posedge pclk);
				chk(disp_word, 32'habc);
				virt_bits <= 12'h5e1;
				repeat (2) @(posedge pclk);
				rd_chk(`PMD_DISP_OFF, 32'h5e1, 1'b0);
				apb(1'b1, `PMD_CTRL_OFF, 32'h0);
				repeat (4) @(posedge pclk);
			end
			if (i == 8) begin
				rd_chk(`PMD_RATE_OFF, 32'(win / 4), 1'b0);
			end
			m.press(1);
			chk({27'h0, monitor_item}, {27'h0, items_list[i]});
			m.press(3);
			chk(disp_word, {27'h0, items_list[i]});
			m.press(1);
		end
		chk({27'h0, monitor_item}, 32'h0);
		m.press(3);
		m.press(0);
		chk(32'(panel_mode), 32'(mode_utility));
		chk({31'h0, show_value}, 32'h0);
		m.press(1);
		chk({27'h0, monitor_item}, 32'h0);
		m.press(0);
		chk(32'(panel_mode), 32'(mode_status));
		conclude();
	end
endmodule
